// File: rtl/bch_pkg.sv
// shared constants, types and address map of the bridge configuration header block
package bch_pkg;

	localparam int ADDR_W = 12;

	// printed offsets are register indices; the byte address is four times the index
	localparam logic [7:0] IDX_CACHE_LINE = 8'h0C;
	localparam logic [7:0] IDX_PRI_LAT = 8'h0D;
	localparam logic [7:0] IDX_HDR_TYPE = 8'h0E;
	localparam logic [7:0] IDX_SELF_TEST = 8'h0F;
	localparam logic [7:0] IDX_BASE_WIN0 = 8'h10;
	localparam logic [7:0] IDX_BASE_WIN1 = 8'h14;
	localparam logic [7:0] IDX_UP_BUS = 8'h18;
	localparam logic [7:0] IDX_DOWN_BUS = 8'h19;
	localparam logic [7:0] IDX_HIGH_BUS = 8'h1A;
	localparam logic [7:0] IDX_DOWN_LAT = 8'h1B;
	localparam logic [7:0] IDX_IO_BASE = 8'h1C;
	localparam logic [7:0] IDX_IO_LIMIT = 8'h1D;

	function automatic logic [ADDR_W-1:0] bchRegAddr(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction

	// reset values and fixed read values
	localparam logic [7:0] RST_CACHE_LINE = 8'h00;
	localparam logic [7:0] RST_BUS_NUM = 8'h00;
	localparam logic [7:0] VAL_ZERO_BYTE = 8'h00;
	localparam logic [31:0] VAL_ZERO_WORD = 32'h0000_0000;
	localparam logic [7:0] HDR_SINGLE = 8'h01;
	localparam logic [7:0] HDR_MULTI = 8'h81;
	localparam logic [4:0] RST_LAT_TIMER = 5'h02;
	localparam logic [2:0] LAT_LOW_BITS = 3'h0;
	localparam int LAT_FIELD_LSB = 3;
	localparam logic [3:0] RST_IO_NIBBLE = 4'h0;
	localparam logic [3:0] IO_CAP_32BIT = 4'h1;
	localparam int IO_FIELD_LSB = 4;
	localparam logic [11:0] IO_LOW_BASE = 12'h000;
	localparam logic [11:0] IO_LOW_LIMIT = 12'hFFF;
	localparam logic [15:0] IO_UPPER_ZERO = 16'h0000;

	typedef enum logic [2:0] {
		CMD_MEM_RD,
		CMD_MEM_RD_LINE,
		CMD_MEM_RD_MULT,
		CMD_MEM_WR,
		CMD_MEM_WR_INV
	} bch_cmd_e;

	typedef enum logic [1:0] {
		STRAP_SYNC1,
		STRAP_SYNC2,
		STRAP_LATCH,
		STRAP_HELD
	} bch_strap_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} bch_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} bch_apb_rsp_s;

	// memory access forwarded from the link towards the secondary bus
	typedef struct packed {
		logic valid;
		logic isWrite;
		logic prefetchable;
		logic [7:0] addrLow;
		logic [7:0] dwords;
		logic allBytes;
	} bch_fwd_req_s;

	typedef struct packed {
		logic [7:0] cacheLine;
		logic [7:0] upBus;
		logic [7:0] downBus;
		logic [7:0] highBus;
		logic [7:0] latencyClocks;
		logic [7:0] headerType;
		logic [31:0] ioBaseAddr;
		logic [31:0] ioLimitAddr;
	} bch_cfg_view_s;

endpackage

// File: rtl/bch_cmd_select.sv
// chooses the secondary bus command for a memory access forwarded from the link
`timescale 1ns/1ps
module bch_cmd_select (
	// configuration
	input wire logic [7:0] cacheLine,
	input wire logic writeInvalidateEnable,
	// access
	input wire bch_pkg::bch_fwd_req_s req,
	output bch_pkg::bch_cmd_e cmd
);
	import bch_pkg::*;

	logic [7:0] lineMask;
	logic [7:0] lineOffset;
	logic [10:0] spanBytes;
	logic [10:0] spanEnd;
	logic crosses;
	logic wholeLine;

	// a power-of-two line size makes size-1 a clean offset mask
	assign lineMask = cacheLine - 8'h01;
	assign lineOffset = req.addrLow & lineMask;
	assign spanBytes = {1'b0, req.dwords, 2'h0};
	assign spanEnd = {3'h0, lineOffset} + spanBytes;
	assign crosses = spanEnd > {3'h0, cacheLine};
	assign wholeLine = (lineOffset == 8'h00) && (spanBytes == {3'h0, cacheLine}) && req.allBytes;

	always_comb begin
		cmd = CMD_MEM_RD;
		if (cacheLine == 8'h00) begin
			cmd = req.isWrite ? CMD_MEM_WR : CMD_MEM_RD; // [R2]
		end else if (req.isWrite) begin
			cmd = (writeInvalidateEnable && wholeLine) ? CMD_MEM_WR_INV : CMD_MEM_WR; // [R4]
		end else if (req.prefetchable && (req.dwords > 8'h01)) begin
			cmd = crosses ? CMD_MEM_RD_MULT : CMD_MEM_RD_LINE; // [R3]
		end
	end
endmodule

// File: rtl/bch_io_decode.sv
// decides whether an I/O address falls inside the programmed I/O window
`timescale 1ns/1ps
module bch_io_decode (
	// window
	input wire logic [3:0] ioBase,
	input wire logic [3:0] ioLimit,
	// access
	input wire logic [31:0] ioAddr,
	output logic hit,
	output logic [31:0] baseAddr,
	output logic [31:0] limitAddr
);
	import bch_pkg::*;

	// upper sixteen window bits live outside this block and are taken as zero
	assign baseAddr = {IO_UPPER_ZERO, ioBase, IO_LOW_BASE}; // [R15]
	assign limitAddr = {IO_UPPER_ZERO, ioLimit, IO_LOW_LIMIT}; // [R16]
	assign hit = (ioAddr >= baseAddr) && (ioAddr <= limitAddr); // [R18]
endmodule

// File: rtl/bch_config_regs.sv
// bridge configuration header bytes 0x0C..0x1D behind an APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// [R1] software writes only power-of-two line sizes
// [R2] zero line size gives plain read/write
// [R3] long prefetchable reads pick multiple or line
// [R4] enabled whole-line writes become write-invalidate
// [R5] software keeps line size at zero
// [R6] primary latency timer reads zero
// [R7] header type strapped, 01h or 81h
// [R8] self-test byte reads zero
// [R9] both base windows read zero, ignore writes
// [R10] upstream bus number RW, warm reset clears
// [R11] downstream bus number RW, warm reset clears
// [R12] highest bus number RW, warm reset clears
// [R13] latency timer upper bits RW, reset 00010
// [R14] latency timer low bits read zero
// [R15] I/O base nibble gives window bits 15:12
// [R16] I/O limit nibble, low bits all ones
// [R17] I/O low nibbles read 1h
// [R18] forward I/O inside window, inclusive
module bch_config_regs (
	// clock and resets
	input wire logic core_clk,
	input wire logic rst,
	input wire logic warmRst,
	// strap pin selecting the multi-function header
	input wire logic laterRevisionCompat,
	// register bus
	input wire bch_pkg::bch_apb_req_s apbReq,
	output bch_pkg::bch_apb_rsp_s apbRsp,
	// command register bit held elsewhere
	input wire logic writeInvalidateEnable,
	// forwarded memory access
	input wire bch_pkg::bch_fwd_req_s fwdReq,
	output logic fwdCmdValid,
	output bch_pkg::bch_cmd_e fwdCmd,
	// I/O access check
	input wire logic ioReqValid,
	input wire logic [31:0] ioAddr,
	output logic ioHitValid,
	output logic ioHit,
	// register contents for the rest of the bridge
	output bch_pkg::bch_cfg_view_s cfgView
);
	import bch_pkg::*;

	typedef struct packed {
		logic [7:0] cacheLine;
		logic [7:0] upBus;
		logic [7:0] downBus;
		logic [7:0] highBus;
		logic [4:0] latTimer;
		logic [3:0] ioBase;
		logic [3:0] ioLimit;
		logic [31:0] rdata;
		logic err;
		bch_strap_e strapSt;
		logic strapS1;
		logic strapS2;
		logic hdrMulti;
		logic fwdValid;
		bch_cmd_e fwdCmd;
		logic ioValid;
		logic ioHit;
	} bch_state_s;

	localparam bch_state_s STATE_RESET = '{
		cacheLine: RST_CACHE_LINE,
		upBus: RST_BUS_NUM,
		downBus: RST_BUS_NUM,
		highBus: RST_BUS_NUM,
		latTimer: RST_LAT_TIMER,
		ioBase: RST_IO_NIBBLE,
		ioLimit: RST_IO_NIBBLE,
		rdata: VAL_ZERO_WORD,
		err: 1'b0,
		strapSt: STRAP_SYNC1,
		strapS1: 1'b0,
		strapS2: 1'b0,
		hdrMulti: 1'b0,
		fwdValid: 1'b0,
		fwdCmd: CMD_MEM_RD,
		ioValid: 1'b0,
		ioHit: 1'b0
	};

	bch_state_s q;
	bch_state_s d;

	logic setupPhase;
	logic writeAccess;
	logic byteLane0;
	logic [7:0] headerType;
	logic [7:0] latencyByte;
	logic [7:0] ioBaseByte;
	logic [7:0] ioLimitByte;
	logic [31:0] readValue;
	logic readErr;
	bch_cmd_e selCmd;
	logic selIoHit;
	logic [31:0] ioBaseAddr;
	logic [31:0] ioLimitAddr;

	// true when the APB address selects the given register index
	function automatic logic isReg(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		return addr == bchRegAddr(idx);
	endfunction

	bch_cmd_select cmdSel (
		.cacheLine(q.cacheLine),
		.writeInvalidateEnable(writeInvalidateEnable),
		.req(fwdReq),
		.cmd(selCmd)
	);

	bch_io_decode ioDec (
		.ioBase(q.ioBase),
		.ioLimit(q.ioLimit),
		.ioAddr(ioAddr),
		.hit(selIoHit),
		.baseAddr(ioBaseAddr),
		.limitAddr(ioLimitAddr)
	);

	// zero-wait slave: read data is fetched during setup, so the access phase always ends at once
	assign setupPhase = apbReq.psel && !apbReq.penable;
	assign writeAccess = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign byteLane0 = apbReq.pstrb[0];

	assign headerType = q.hdrMulti ? HDR_MULTI : HDR_SINGLE; // [R7]
	assign latencyByte = {q.latTimer, LAT_LOW_BITS}; // [R14]
	assign ioBaseByte = {q.ioBase, IO_CAP_32BIT}; // [R17]
	assign ioLimitByte = {q.ioLimit, IO_CAP_32BIT}; // [R17]

	always_comb begin
		readValue = VAL_ZERO_WORD;
		readErr = 1'b0;
		if (isReg(apbReq.paddr, IDX_CACHE_LINE)) begin
			readValue = {24'h000000, q.cacheLine};
		end else if (isReg(apbReq.paddr, IDX_PRI_LAT)) begin
			readValue = {24'h000000, VAL_ZERO_BYTE}; // [R6]
		end else if (isReg(apbReq.paddr, IDX_HDR_TYPE)) begin
			readValue = {24'h000000, headerType}; // [R7]
		end else if (isReg(apbReq.paddr, IDX_SELF_TEST)) begin
			readValue = {24'h000000, VAL_ZERO_BYTE}; // [R8]
		end else if (isReg(apbReq.paddr, IDX_BASE_WIN0)) begin
			readValue = VAL_ZERO_WORD; // [R9]
		end else if (isReg(apbReq.paddr, IDX_BASE_WIN1)) begin
			readValue = VAL_ZERO_WORD; // [R9]
		end else if (isReg(apbReq.paddr, IDX_UP_BUS)) begin
			readValue = {24'h000000, q.upBus};
		end else if (isReg(apbReq.paddr, IDX_DOWN_BUS)) begin
			readValue = {24'h000000, q.downBus};
		end else if (isReg(apbReq.paddr, IDX_HIGH_BUS)) begin
			readValue = {24'h000000, q.highBus};
		end else if (isReg(apbReq.paddr, IDX_DOWN_LAT)) begin
			readValue = {24'h000000, latencyByte};
		end else if (isReg(apbReq.paddr, IDX_IO_BASE)) begin
			readValue = {24'h000000, ioBaseByte};
		end else if (isReg(apbReq.paddr, IDX_IO_LIMIT)) begin
			readValue = {24'h000000, ioLimitByte};
		end else begin
			readErr = 1'b1;
		end
	end

	always_comb begin
		d = q;

		// bus read path
		if (setupPhase) begin
			d.rdata = apbReq.pwrite ? VAL_ZERO_WORD : readValue;
			d.err = readErr;
		end

		// register writes; only byte lane 0 carries the byte-wide registers
		if (writeAccess && byteLane0) begin
			if (isReg(apbReq.paddr, IDX_CACHE_LINE)) begin
				// stored as written; values other than zero or a power of two are the software's responsibility
				d.cacheLine = apbReq.pwdata[7:0];
			end
			if (isReg(apbReq.paddr, IDX_UP_BUS)) begin
				d.upBus = apbReq.pwdata[7:0]; // [R10]
			end
			if (isReg(apbReq.paddr, IDX_DOWN_BUS)) begin
				d.downBus = apbReq.pwdata[7:0]; // [R11]
			end
			if (isReg(apbReq.paddr, IDX_HIGH_BUS)) begin
				d.highBus = apbReq.pwdata[7:0]; // [R12]
			end
			if (isReg(apbReq.paddr, IDX_DOWN_LAT)) begin
				d.latTimer = apbReq.pwdata[7:LAT_FIELD_LSB]; // [R13]
			end
			if (isReg(apbReq.paddr, IDX_IO_BASE)) begin
				d.ioBase = apbReq.pwdata[7:IO_FIELD_LSB]; // [R15]
			end
			if (isReg(apbReq.paddr, IDX_IO_LIMIT)) begin
				d.ioLimit = apbReq.pwdata[7:IO_FIELD_LSB]; // [R16]
			end
		end

		// warm reset outranks a write in the same cycle
		if (warmRst) begin
			d.upBus = RST_BUS_NUM; // [R10]
			d.downBus = RST_BUS_NUM; // [R11]
			d.highBus = RST_BUS_NUM; // [R12]
			d.latTimer = RST_LAT_TIMER; // [R13]
			d.ioBase = RST_IO_NIBBLE; // [R15]
			d.ioLimit = RST_IO_NIBBLE; // [R16]
		end

		// strap: synchronise, then hold one sampled value until the next cold reset
		d.strapS1 = laterRevisionCompat;
		d.strapS2 = q.strapS1;
		case (q.strapSt)
			STRAP_SYNC1: begin
				d.strapSt = STRAP_SYNC2;
			end
			STRAP_SYNC2: begin
				d.strapSt = STRAP_LATCH;
			end
			// the second flop holds the pin value only from the second edge on
			STRAP_LATCH: begin
				d.strapSt = STRAP_HELD;
				d.hdrMulti = q.strapS2; // [R7]
			end
			STRAP_HELD: begin
				d.strapSt = STRAP_HELD;
			end
			default: begin
				d.strapSt = STRAP_SYNC1;
			end
		endcase

		// forwarded access results, one cycle after the request
		d.fwdValid = fwdReq.valid;
		if (fwdReq.valid) begin
			d.fwdCmd = selCmd; // [R2]
		end
		d.ioValid = ioReqValid;
		if (ioReqValid) begin
			d.ioHit = selIoHit; // [R18]
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= STATE_RESET;
		end else begin
			q <= d;
		end
	end

	assign apbRsp.prdata = q.rdata;
	assign apbRsp.pready = 1'b1;
	assign apbRsp.pslverr = apbReq.psel && apbReq.penable && q.err;

	assign fwdCmdValid = q.fwdValid;
	assign fwdCmd = q.fwdCmd;
	assign ioHitValid = q.ioValid;
	assign ioHit = q.ioHit;

	assign cfgView.cacheLine = q.cacheLine;
	assign cfgView.upBus = q.upBus;
	assign cfgView.downBus = q.downBus;
	assign cfgView.highBus = q.highBus;
	assign cfgView.latencyClocks = latencyByte;
	assign cfgView.headerType = headerType;
	assign cfgView.ioBaseAddr = ioBaseAddr;
	assign cfgView.ioLimitAddr = ioLimitAddr;
endmodule

// File: test/bch_config_regs_assertions.sv
// checker for the configuration header bank
`timescale 1ns/1ps
module bch_config_regs_assertions (
	// clock and resets
	input wire logic core_clk,
	input wire logic rst,
	input wire logic warmRst,
	input wire logic laterRevisionCompat,
	// register bus
	input wire bch_pkg::bch_apb_req_s apbReq,
	input wire bch_pkg::bch_apb_rsp_s apbRsp,
	// forwarding and I/O
	input wire logic writeInvalidateEnable,
	input wire bch_pkg::bch_fwd_req_s fwdReq,
	input wire logic fwdCmdValid,
	input wire bch_pkg::bch_cmd_e fwdCmd,
	input wire logic ioReqValid,
	input wire logic [31:0] ioAddr,
	input wire logic ioHitValid,
	input wire logic ioHit,
	input wire bch_pkg::bch_cfg_view_s cfgView
);
	import bch_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic acc;
	assign acc = apbReq.psel && apbReq.penable;
	AST_PLAIN_CMD: assert property (
		fwdReq.valid && cfgView.cacheLine == 8'h00 |=> fwdCmdValid
		&& fwdCmd == ($past(fwdReq.isWrite) ? CMD_MEM_WR : CMD_MEM_RD))
		else $error("plain command expected");
	AST_LAT_LOW: assert property (cfgView.latencyClocks[2:0] == 3'h0)
		else $error("latency low bits set");
	AST_IO_LOW: assert property (
		cfgView.ioBaseAddr[11:0] == 12'h000 && cfgView.ioLimitAddr[11:0] == 12'hFFF)
		else $error("io window low bits wrong");
	// the header type may only move from single to multi, and only with the strap high
	AST_HDR: assert property ($changed(cfgView.headerType) |->
		cfgView.headerType == HDR_MULTI && $past(laterRevisionCompat, 2))
		else $error("bad header type");
	AST_WARM: assert property (warmRst |=> cfgView.upBus == 8'h00 && cfgView.downBus == 8'h00
		&& cfgView.highBus == 8'h00 && cfgView.latencyClocks == 8'h10
		&& cfgView.ioBaseAddr[15:12] == 4'h0 && cfgView.ioLimitAddr[15:12] == 4'h0)
		else $error("warm reset did not clear");
	AST_IO_HIT: assert property (ioReqValid |=> ioHitValid && ioHit ==
		($past(ioAddr) >= $past(cfgView.ioBaseAddr) && $past(ioAddr) <= $past(cfgView.ioLimitAddr)))
		else $error("io window decision wrong");
	AST_RD_ZERO: assert property (
		acc && !apbReq.pwrite && apbReq.paddr inside {12'h034, 12'h03C, 12'h040, 12'h050}
		|-> apbRsp.prdata == 32'h0) else $error("fixed zero register not zero");
	AST_IO_CAP: assert property (
		acc && !apbReq.pwrite && apbReq.paddr inside {12'h070, 12'h074}
		|-> apbRsp.prdata[3:0] == 4'h1) else $error("io capability nibble wrong");
	AST_WR_LAT: assert property (
		acc && apbReq.pwrite && apbReq.pstrb[0] && apbReq.paddr == 12'h06C && !warmRst
		|=> cfgView.latencyClocks == {$past(apbReq.pwdata[7:3]), 3'h0})
		else $error("latency write lost");
	cover property (warmRst);
	cover property (fwdCmdValid && fwdCmd == CMD_MEM_WR_INV);
	cover property (ioHitValid && ioHit);
endmodule
bind bch_config_regs bch_config_regs_assertions u_chk (.core_clk(core_clk), .rst(rst),
	.warmRst(warmRst), .laterRevisionCompat(laterRevisionCompat), .apbReq(apbReq),
	.apbRsp(apbRsp), .writeInvalidateEnable(writeInvalidateEnable), .fwdReq(fwdReq),
	.fwdCmdValid(fwdCmdValid), .fwdCmd(fwdCmd), .ioReqValid(ioReqValid), .ioAddr(ioAddr),
	.ioHitValid(ioHitValid), .ioHit(ioHit), .cfgView(cfgView));

// File: test/bch_host_model.sv
// APB master standing in for configuration software
`timescale 1ns/1ps
module bch_host_model (
	// clock
	input wire logic core_clk,
	// register bus
	output bch_pkg::bch_apb_req_s apbReq,
	input wire bch_pkg::bch_apb_rsp_s apbRsp
);
	import bch_pkg::*;
	initial apbReq = '0;
	// the request is held until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hF};
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (apbRsp.pready === 1'b1)
				break;
		end
		apbReq <= '0;
	endtask
endmodule

// File: test/bch_config_regs_test.sv
// self-checking bench for the configuration header bank
`timescale 1ns/1ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module bch_config_regs_test;
	import bch_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, warmRst = 1'b0, strap = 1'b0, wie = 1'b0;
	logic ioReqValid = 1'b0, fwdCmdValid, ioHitValid, ioHit;
	logic [31:0] ioAddr = '0;
	logic [31:0] wv[12];
	logic [32:0] expQ[$];
	bch_apb_req_s apbReq;
	bch_apb_rsp_s apbRsp;
	bch_fwd_req_s fwdReq = '0;
	bch_cmd_e fwdCmd;
	bch_cfg_view_s cfgView;
	int errors = 0, nCompared = 0;
	localparam logic [11:0] ADR[12] = '{12'h030, 12'h034, 12'h038, 12'h03C, 12'h040,
		12'h050, 12'h060, 12'h064, 12'h068, 12'h06C, 12'h070, 12'h074};
	localparam logic [7:0] MSK[12] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hFF, 8'hFF, 8'hFF, 8'hF8, 8'hF0, 8'hF0};
	localparam logic [7:0] FIX[12] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
	initial forever #5 core_clk = ~core_clk;
	bch_host_model u_host (.core_clk(core_clk), .apbReq(apbReq), .apbRsp(apbRsp));
	bch_config_regs u_dut (.core_clk(core_clk), .rst(rst), .warmRst(warmRst),
		.laterRevisionCompat(strap), .apbReq(apbReq), .apbRsp(apbRsp),
		.writeInvalidateEnable(wie), .fwdReq(fwdReq), .fwdCmdValid(fwdCmdValid),
		.fwdCmd(fwdCmd), .ioReqValid(ioReqValid), .ioAddr(ioAddr), .ioHitValid(ioHitValid),
		.ioHit(ioHit), .cfgView(cfgView));
	// mode 0 after reset, 1 after writes, 2 after warm reset (line size survives)
	function automatic logic [32:0] expOf(int i, int m);
		logic [7:0] r;
		r = FIX[i] | ((i == 9) ? 8'h10 : 8'h00);
		if (m == 1 || (m == 2 && i == 0))
			r = (wv[i][7:0] & MSK[i]) | FIX[i];
		return {25'h0, r};
	endfunction
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		expQ.push_back(e);
		u_host.xfer(1'b0, a, 32'h0);
	endtask
	task automatic fwd(input logic w, pf, input logic [7:0] a, dw, input logic al, we,
		input bch_cmd_e c);
		@(posedge core_clk);
		wie <= we;
		fwdReq <= '{1'b1, w, pf, a, dw, al};
		expQ.push_back({30'h0, c});
	endtask
	task automatic io(input logic [31:0] a);
		@(posedge core_clk);
		ioReqValid <= 1'b1;
		ioAddr <= a;
		expQ.push_back({32'h0, a >= {16'h0, wv[10][7:4], 12'h000}
			&& a <= {16'h0, wv[11][7:4], 12'hFFF}});
	endtask
	task automatic idle();
		@(posedge core_clk);
		ioReqValid <= 1'b0;
		fwdReq <= '0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic test_done();
		$display("compared %0d errors %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [32:0] nextExp();
		return expQ.size() ? expQ.pop_front() : 'x;
	endfunction
	always @(posedge core_clk) begin
		logic [32:0] e;
		if (!rst && apbReq.psel && apbReq.penable && apbRsp.pready && !apbReq.pwrite) begin
			e = nextExp();
			`CHK({apbRsp.pslverr, apbRsp.prdata}, e)
		end
		if (!rst && fwdCmdValid) begin
			e = nextExp();
			`CHK({30'h0, fwdCmd}, e)
		end
		if (!rst && ioHitValid) begin
			e = nextExp();
			`CHK({32'h0, ioHit}, e)
		end
	end
	initial begin
		#200us;
		errors++;
		test_done();
	end
	initial begin
		logic [31:0] b, l;
		void'($urandom(32'h1fff2a7c));
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++) rd(ADR[i], expOf(i, 0));
		for (int i = 0; i < 12; i++) begin
			wv[i] = $urandom();
			if (i == 0)
				wv[0] = 32'h1 << ($urandom() % 8);
			u_host.xfer(1'b1, ADR[i], wv[i]);
		end
		for (int i = 0; i < 12; i++) rd(ADR[i], expOf(i, 1));
		rd(12'h044, {1'b1, 32'h0});
		b = {16'h0, wv[10][7:4], 12'h000};
		l = {16'h0, wv[11][7:4], 12'hFFF};
		io(b);
		io(b - 32'h1);
		io(l);
		io(l + 32'h1);
		io(b | 32'h0001_0000);
		idle();
		u_host.xfer(1'b1, 12'h030, 32'h20);
		fwd(1'b0, 1'b1, 8'h00, 8'd2, 1'b1, 1'b0, CMD_MEM_RD_LINE);
		fwd(1'b0, 1'b1, 8'h1C, 8'd2, 1'b1, 1'b0, CMD_MEM_RD_MULT);
		fwd(1'b0, 1'b1, 8'h00, 8'd1, 1'b1, 1'b0, CMD_MEM_RD);
		fwd(1'b0, 1'b0, 8'h00, 8'd4, 1'b1, 1'b0, CMD_MEM_RD);
		fwd(1'b1, 1'b0, 8'h00, 8'd8, 1'b1, 1'b1, CMD_MEM_WR_INV);
		fwd(1'b1, 1'b0, 8'h00, 8'd8, 1'b0, 1'b1, CMD_MEM_WR);
		fwd(1'b1, 1'b0, 8'h04, 8'd8, 1'b1, 1'b1, CMD_MEM_WR);
		fwd(1'b1, 1'b0, 8'h00, 8'd8, 1'b1, 1'b0, CMD_MEM_WR);
		idle();
		u_host.xfer(1'b1, 12'h030, 32'h0);
		wv[0] = 32'h0;
		fwd(1'b0, 1'b1, 8'h1C, 8'd2, 1'b1, 1'b1, CMD_MEM_RD);
		fwd(1'b1, 1'b0, 8'h00, 8'd8, 1'b1, 1'b1, CMD_MEM_WR);
		idle();
		warmRst <= 1'b1;
		@(posedge core_clk);
		warmRst <= 1'b0;
		for (int i = 0; i < 12; i++) rd(ADR[i], expOf(i, 2));
		rst <= 1'b1;
		strap <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd(12'h038, {25'h0, HDR_MULTI});
		repeat (3) @(posedge core_clk);
		if (expQ.size() != 0)
			errors++;
		test_done();
	end
endmodule
